// ### hdl/two_wire_register_access_slave.v
// Two-wire slave engine giving byte access to the shadow register space
`timescale 1ns/1ps
`include "two_wire_slave_map.vh"

module two_wire_register_access_slave (
    input wire mclk,
    input wire reset_n,
    input wire scl,
    input wire sda_i,
    output wire sda_o,
    output reg sda_oe,
    input wire [3:0] user_addr,
    output reg [7:0] rd_addr,
    input wire [7:0] rd_data,
    input wire wr_allowed,
    output reg [7:0] wr_addr,
    output reg [7:0] wr_data,
    output reg wr_en
);

////////////////////////////////////////////////////////////////////////////////
localparam [3:0] ST_IDLE = 4'h0;
localparam [3:0] ST_ADDR = 4'h1;
localparam [3:0] ST_ADDR_ACK = 4'h2;
localparam [3:0] ST_PTR = 4'h3;
localparam [3:0] ST_PTR_ACK = 4'h4;
localparam [3:0] ST_WDATA = 4'h5;
localparam [3:0] ST_WDATA_ACK = 4'h6;
localparam [3:0] ST_RDATA = 4'h7;
localparam [3:0] ST_RDATA_ACK = 4'h8;

// Write permission for the byte about to land at ptr
function write_ok;
    input [7:0] ptr;
    input past;
    input first;
    input allowed;
    begin
        write_ok = !past && ((ptr <= `WRITE_TOP_ADDR && allowed) ||
            (ptr == `COMMAND_ADDR && first));
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Helpers shared by the engine

// Byte queued for the wire; past the top SDA is simply left to the
// pull-up, so the master reads all ones without any map lookup
function [7:0] load_byte;
    input past;
    input [7:0] data;
    begin
        if (past) begin
            load_byte = `PAST_TOP_FILL;
        end else begin
            load_byte = data;
        end
    end
endfunction

// Pointer after one byte; it wraps at eight bits like the map
function [7:0] ptr_step;
    input [7:0] ptr;
    begin
        ptr_step = ptr + 8'h01;
    end
endfunction

// The byte just finished sat at the last location
function ptr_at_top;
    input [7:0] ptr;
    begin
        ptr_at_top = (ptr == `LAST_ADDR);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Reset release
reg rst_s1;
reg rst_n;

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        rst_s1 <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_s1 <= 1'b1;
        rst_n <= rst_s1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin sampling: a level counts once stages two and three agree
reg [2:0] scl_sh;
reg [2:0] sda_sh;
reg scl_f;
reg sda_f;
reg scl_prev;
reg sda_prev;

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        scl_sh <= 3'h7;
        sda_sh <= 3'h7;
        scl_f <= 1'b1;
        sda_f <= 1'b1;
        scl_prev <= 1'b1;
        sda_prev <= 1'b1;
    end else begin
        scl_sh <= {scl_sh[1:0], scl};
        sda_sh <= {sda_sh[1:0], sda_i};
        if (scl_sh[1] == scl_sh[2]) begin
            scl_f <= scl_sh[2];
        end
        if (sda_sh[1] == sda_sh[2]) begin
            sda_f <= sda_sh[2];
        end
        scl_prev <= scl_f;
        sda_prev <= sda_f;
    end
end

wire scl_rise = scl_f && !scl_prev;
wire scl_fall = !scl_f && scl_prev;
// SDA moving while SCL stays high marks a bus condition
wire start_seen = scl_f && scl_prev && sda_prev && !sda_f;
wire stop_seen = scl_f && scl_prev && !sda_prev && sda_f;

assign sda_o = 1'b0;

////////////////////////////////////////////////////////////////////////////////
// Protocol engine
reg [3:0] state;
reg [3:0] bit_cnt;
reg [7:0] shift;
reg [7:0] tx;
reg is_read;
reg past_top;
reg first_byte;
reg master_nack;
reg pend_ok;
reg [7:0] pend_addr;
reg [7:0] pend_data;

// Read byte for the next data phase, and the end of a received byte
wire [7:0] next_tx = load_byte(past_top, rd_data);
wire byte_done = scl_fall && (bit_cnt == `BITS_PER_BYTE);

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        state <= ST_IDLE;
        bit_cnt <= 4'h0;
        shift <= 8'h00;
        tx <= 8'h00;
        is_read <= 1'b0;
        past_top <= 1'b0;
        first_byte <= 1'b0;
        master_nack <= 1'b0;
        pend_ok <= 1'b0;
        pend_addr <= 8'h00;
        pend_data <= 8'h00;
        sda_oe <= 1'b0;
        rd_addr <= 8'h00;
        wr_addr <= 8'h00;
        wr_data <= 8'h00;
        wr_en <= 1'b0;
    end else begin
        wr_en <= 1'b0;
        if (stop_seen) begin
            // Half-received bytes and pending writes are dropped here
            state <= ST_IDLE;
            sda_oe <= 1'b0;
        end else if (start_seen) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_f};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt <= 4'h0;
                        if (shift[7:1] == {`ADDR_FIXED_BITS, user_addr}) begin
                            sda_oe <= 1'b1;
                            is_read <= shift[0];
                            state <= ST_ADDR_ACK;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_PTR: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_f};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt <= 4'h0;
                        // A new pointer starts a fresh run, so its first byte may hit the command location
                        rd_addr <= shift;
                        past_top <= 1'b0;
                        first_byte <= 1'b1;
                        sda_oe <= 1'b1;
                        state <= ST_PTR_ACK;
                    end
                end
                ST_WDATA: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_f};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt <= 4'h0;
                        pend_addr <= rd_addr;
                        pend_data <= shift;
                        pend_ok <= write_ok(rd_addr, past_top, first_byte, wr_allowed);
                        // Pointer moves on the SCL fall that ends the LSB, so the
                        // next byte can follow the acknowledge directly
                        rd_addr <= ptr_step(rd_addr);
                        if (ptr_at_top(rd_addr)) begin
                            past_top <= 1'b1;
                        end
                        first_byte <= 1'b0;
                        sda_oe <= 1'b1;
                        state <= ST_WDATA_ACK;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (is_read) begin
                            tx <= next_tx;
                            sda_oe <= !next_tx[7];
                            state <= ST_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state <= ST_PTR;
                        end
                    end
                end
                ST_PTR_ACK: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        state <= ST_WDATA;
                    end
                end
                ST_WDATA_ACK: begin
                    // Commit only once the acknowledge clock has completed
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        wr_en <= pend_ok;
                        // Address and data keep their last committed values
                        if (pend_ok) begin
                            wr_addr <= pend_addr;
                            wr_data <= pend_data;
                        end
                        state <= ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt == `BITS_PER_BYTE) begin
                            sda_oe <= 1'b0;
                            // Last bit is out: step now so the next byte is ready at the ack fall
                            rd_addr <= ptr_step(rd_addr);
                            if (ptr_at_top(rd_addr)) begin
                                past_top <= 1'b1;
                            end
                            state <= ST_RDATA_ACK;
                        end else begin
                            tx <= {tx[6:0], 1'b1};
                            sda_oe <= !tx[6];
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        master_nack <= sda_f;
                    end else if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (master_nack) begin
                            sda_oe <= 1'b0;
                            state <= ST_IDLE;
                        end else begin
                            // Master acknowledged: queue the following byte
                            tx <= next_tx;
                            sda_oe <= !next_tx[7];
                            state <= ST_RDATA;
                        end
                    end
                end
                ST_IDLE: begin
                    // Deaf to the bus until the next START
                    sda_oe <= 1'b0;
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end
end

endmodule

// ### hdl/two_wire_slave_map.vh
// Constants for the two-wire register access slave
`ifndef TWO_WIRE_SLAVE_MAP_VH
`define TWO_WIRE_SLAVE_MAP_VH
`define ADDR_FIXED_BITS 3'h3
`define WRITE_TOP_ADDR 8'h4F
`define COMMAND_ADDR 8'hFE
`define PAST_TOP_FILL 8'hFF
`define LAST_ADDR 8'hFF
`define BITS_PER_BYTE 4'h8
`endif

// ### verification/bus_master_model.sv
// Behavioural bus master that drives SCL and its side of SDA
`timescale 1ns/1ps
module bus_master_model (
    output reg scl,
    output reg m_oe,
    input wire sda
);
    initial begin
        scl = 1'b1;
        m_oe = 1'b0;
    end
    // Released first, so a device ack still standing cannot fake a stop
    task start;
        begin
            #30 m_oe = 1'b0;
            #50 scl = 1'b1;
            #40 m_oe = 1'b1;
            #40 scl = 1'b0;
        end
    endtask
    task stop;
        begin
            #30 m_oe = 1'b1;
            #50 scl = 1'b1;
            #80 m_oe = 1'b0;
        end
    endtask
    task bitx(input b, output r);
        begin
            // One bit per 160 ns clock; data moves well clear of both edges
            #30 m_oe = ~b;
            #50 scl = 1'b1;
            #40 r = sda;
            #40 scl = 1'b0;
        end
    endtask
    task wbyte(input [7:0] v, output ack);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1)
                bitx(v[i], r);
            bitx(1'b1, r);
            ack = ~r;
        end
    endtask
    task rbyte(input ack, output [7:0] v);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                bitx(1'b1, r);
                v[i] = r;
            end
            bitx(~ack, r);
        end
    endtask
endmodule

// ### verification/two_wire_slave_sva.sv
// Port assertions for the two-wire register access slave
`timescale 1ns/1ps
module two_wire_slave_sva (
    input wire mclk,
    input wire reset_n,
    input wire scl,
    input wire sda_oe,
    input wire [7:0] rd_addr,
    input wire [7:0] wr_addr,
    input wire wr_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_wr_one_cycle: assert property (wr_en |=> !wr_en)
        else $error("write strobe too long");
    a_wr_in_range: assert property (wr_en |-> (wr_addr <= 8'h4F || wr_addr == 8'hFE))
        else $error("write above top");
    a_wr_ptr_behind: assert property (wr_en |-> rd_addr == wr_addr + 8'h01)
        else $error("pointer not advanced");
    a_wr_addr_tied: assert property ($changed(wr_addr) |-> wr_en)
        else $error("write address moved");
    a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl)
        else $error("drive began with clock high");
    a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl)
        else $error("release with clock high");
    a_ptr_on_low: assert property ($changed(rd_addr) |-> !scl)
        else $error("pointer moved with clock high");
    a_oe_holds: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("drive too short");
    c_write: cover property (wr_en);
    c_drive: cover property ($rose(sda_oe));
    c_top: cover property (rd_addr == 8'hFF);
endmodule

// ### verification/two_wire_register_access_slave_bench.sv
// Scenario bench for the two-wire register access slave
`timescale 1ns/1ps
module two_wire_register_access_slave_bench;
    reg mclk = 1'b0;
    reg reset_n = 1'b0;
    reg [3:0] user_addr = 4'h6;
    reg [7:0] mem [0:255];
    integer miscompares = 0;
    integer total_checks = 0;
    integer i;
    reg ack;
    reg [7:0] d;
    wire scl, m_oe, sda_oe, sda_o, wr_en;
    wire [7:0] rd_addr, wr_addr, wr_data;
    // Open-drain wire with a pull-up: either side may only pull it low
    wire sda = (sda_oe ? sda_o : 1'b1) & ~m_oe;
    // Read-only block at 10h..1Fh is an arbitrary map choice
    wire wr_allowed = rd_addr[7:4] != 4'h1;
    wire [7:0] rd_data = mem[rd_addr];
    two_wire_register_access_slave two_wire_register_access_slave_i (.mclk(mclk), .reset_n(reset_n), .scl(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .user_addr(user_addr), .rd_addr(rd_addr),
        .rd_data(rd_data), .wr_allowed(wr_allowed), .wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en));
    bus_master_model bus_master_model_i (.scl(scl), .m_oe(m_oe), .sda(sda));
    always @(posedge mclk) begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end
    initial begin
        forever #5 mclk = ~mclk;
    end
    task check(input string name, input [7:0] exp, input [7:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task addr(input rw);
        begin
            bus_master_model_i.start;
            bus_master_model_i.wbyte({3'h3, user_addr, rw}, ack);
            check("addr ack", 8'h01, {7'h00, ack});
        end
    endtask
    task setp(input [7:0] p);
        begin
            addr(1'b0);
            bus_master_model_i.wbyte(p, ack);
            check("ptr ack", 8'h01, {7'h00, ack});
        end
    endtask
    task t_probe;
        begin
            bus_master_model_i.start;
            bus_master_model_i.wbyte(8'h5C, ack);
            check("probe miss", 8'h00, {7'h00, ack});
            bus_master_model_i.stop;
            bus_master_model_i.start;
            bus_master_model_i.wbyte({3'h3, user_addr ^ 4'h1, 1'b0}, ack);
            check("user bits miss", 8'h00, {7'h00, ack});
            bus_master_model_i.stop;
            addr(1'b0);
            bus_master_model_i.stop;
            user_addr = 4'h9;
            addr(1'b0);
            bus_master_model_i.stop;
            user_addr = 4'h6;
        end
    endtask
    task t_write;
        begin
            setp(8'h4E);
            for (i = 0; i < 3; i = i + 1) begin
                bus_master_model_i.wbyte(8'hA1 + 8'h11 * i[7:0], ack);
                check("data ack", 8'h01, {7'h00, ack});
            end
            bus_master_model_i.stop;
            check("mem 4E", 8'hA1, mem[8'h4E]);
            check("mem 4F", 8'hB2, mem[8'h4F]);
            check("mem 50", 8'h50 ^ 8'hA5, mem[8'h50]);
        end
    endtask
    task t_discard;
        begin
            setp(8'h10);
            bus_master_model_i.wbyte(8'h55, ack);
            bus_master_model_i.stop;
            check("mem 10", 8'h10 ^ 8'hA5, mem[8'h10]);
            setp(8'h20);
            for (i = 0; i < 4; i = i + 1)
                bus_master_model_i.bitx(1'b0, ack);
            bus_master_model_i.stop;
            check("mem 20", 8'h20 ^ 8'hA5, mem[8'h20]);
        end
    endtask
    task t_read;
        begin
            setp(8'h4E);
            addr(1'b1);
            bus_master_model_i.rbyte(1'b1, d);
            check("read 4E", 8'hA1, d);
            bus_master_model_i.rbyte(1'b0, d);
            check("read 4F", 8'hB2, d);
            #60;
            check("released", 8'h00, {7'h00, sda_oe});
            bus_master_model_i.rbyte(1'b0, d);
            check("after nack", 8'hFF, d);
            bus_master_model_i.stop;
        end
    endtask
    task t_top;
        begin
            setp(8'hFD);
            bus_master_model_i.wbyte(8'h11, ack);
            bus_master_model_i.wbyte(8'h22, ack);
            bus_master_model_i.stop;
            check("mem FD", 8'hFD ^ 8'hA5, mem[8'hFD]);
            check("mem FE inc", 8'hFE ^ 8'hA5, mem[8'hFE]);
            setp(8'hFE);
            bus_master_model_i.wbyte(8'h3C, ack);
            check("cmd ack", 8'h01, {7'h00, ack});
            bus_master_model_i.wbyte(8'h77, ack);
            bus_master_model_i.stop;
            check("mem FE first", 8'h3C, mem[8'hFE]);
            check("mem FF", 8'hFF ^ 8'hA5, mem[8'hFF]);
            setp(8'hFE);
            addr(1'b1);
            for (i = 0; i < 4; i = i + 1) begin
                bus_master_model_i.rbyte(i < 3, d);
                check("read top", i == 0 ? 8'h3C : (i == 1 ? 8'hFF ^ 8'hA5 : 8'hFF), d);
            end
            bus_master_model_i.stop;
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, miscompares);
            if (miscompares == 0 && total_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        for (i = 0; i < 256; i = i + 1)
            mem[i] = i[7:0] ^ 8'hA5;
        repeat (20) @(negedge mclk);
        reset_n = 1'b1;
        repeat (10) @(negedge mclk);
        t_probe;
        t_write;
        t_discard;
        t_read;
        t_top;
        give_verdict;
    end
    initial begin
        #400000;
        miscompares = miscompares + 1;
        give_verdict;
    end
endmodule
bind two_wire_register_access_slave two_wire_slave_sva two_wire_slave_sva_i (.mclk(mclk), .reset_n(reset_n),
    .scl(scl), .sda_oe(sda_oe), .rd_addr(rd_addr), .wr_addr(wr_addr), .wr_en(wr_en));
